// *** ccs_circ_agen.sv ***
`timescale 1ns/100ps
`default_nettype none
module ccs_circ_agen
    import ccs_pkg::*;
(
    input wire logic [31:0] bounds_i,
    input wire logic x_en_i,
    input wire logic y_en_i,
    input wire logic [31:0] x_addr_i,
    input wire logic [31:0] y_addr_i,
    output logic [31:0] x_next_o,
    output logic [31:0] y_next_o
);
    logic [CCS_MOD_W-1:0] lo;
    logic [CCS_MOD_W-1:0] hi;
    logic both;

    assign lo = bounds_i[CCS_MOD_W-1:0];
    assign hi = bounds_i[CCS_MOD_HI_LSB +: CCS_MOD_W];
    // both enables set wraps neither pointer
    assign both = x_en_i && y_en_i;

    always_comb
    begin
        x_next_o = x_addr_i;
        y_next_o = y_addr_i;
        // wrap X pointer at end bound
        if (x_en_i && !both && x_addr_i[CCS_MOD_W-1:0] == hi)
        begin
            x_next_o = {x_addr_i[31:CCS_MOD_W], lo};
        end
        // wrap Y pointer at end bound
        if (y_en_i && !both && y_addr_i[CCS_MOD_W-1:0] == hi)
        begin
            y_next_o = {y_addr_i[31:CCS_MOD_W], lo};
        end
    end
endmodule // ccs_circ_agen
`default_nettype wire

// *** ccs_ctrl_regs.sv ***
// How it works
// - X circular enable set wraps the X pointer on X transfers.
// - Y circular enable set wraps the Y pointer on Y transfers.
// - Both enables set is reserved; software must not rely on it.
// - Single transfers never get circular wrapping.
// - Size code 00 one, 01 two, 11 three, 10 four or more steps.
// - Repeat setup writes the loop size code.
// - Status word holds a twelve-bit repeat count.
// - Circular enables, count, size code writable in privileged or DSP modes.
// - A status word load may change count and size code.
// - Loop start and end pointers hold loop bounds.
// - Bounds register holds circular start and end.
// - Control load/store reach loop and bounds; memory forms step pointer by 4.
// - Loop setup writes displacement times two plus program counter.
// - Privilege bit 1 is privileged mode, 0 user mode.
// - Bank select picks active bank in privileged mode; other bank via control ops.
// - Interrupt hold set blocks interrupts.
// - DSP enable off makes all DSP class operations illegal.
// - Status word carries a four-bit interrupt mask level.
// - True flag records compare outcomes and carry or overflow.
// - Saturation flag serves multiply-accumulate and DSP data.
// - Reserved status bits read zero; software writes zero.
// - Address at end bound reloads the enabled pointer with start bound.
`timescale 1ns/100ps
`default_nettype none
module ccs_ctrl_regs
    import ccs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic op_valid_i,
    input wire ccs_op_t op_i,
    input wire ccs_sel_t sel_i,
    input wire logic [31:0] wdata_i,
    input wire logic [31:0] ptr_i,
    input wire logic [11:0] rc_i,
    input wire logic [1:0] rf_i,
    input wire logic [31:0] disp_i,
    input wire logic [31:0] pc_i,
    input wire logic [31:0] x_addr_i,
    input wire logic [31:0] y_addr_i,
    input wire logic [31:0] s_addr_i,
    input wire logic t_we_i,
    input wire logic t_i,
    input wire logic s_we_i,
    input wire logic s_i,
    input wire logic qm_we_i,
    input wire logic q_i,
    input wire logic m_i,
    output logic [31:0] status_word_o,
    output logic [31:0] loop_start_ptr_o,
    output logic [31:0] loop_end_ptr_o,
    output logic [31:0] circular_bounds_o,
    output logic [31:0] ctrl_rdata_o,
    output logic illegal_o,
    output logic [31:0] ptr_upd_o,
    output logic [31:0] x_ptr_o,
    output logic [31:0] y_ptr_o,
    output logic [31:0] s_ptr_o,
    output logic priv_mode_o,
    output logic active_bank_o,
    output logic ctrl_bank_o,
    output logic int_accept_o,
    output logic [3:0] irq_mask_o,
    output logic dsp_en_o,
    output logic [2:0] loop_steps_o
);
    ccs_state_t q;
    ccs_state_t d;
    logic [31:0] x_next;
    logic [31:0] y_next;
    logic [31:0] rd_mux;

    ccs_dec_if dif ();

    assign dif.op = op_i;
    assign dif.sel = sel_i;
    assign dif.priv = q.sr[CCS_SR_MD];
    assign dif.dsp = q.sr[CCS_SR_DSP];

    ccs_decode u_dec (
        .dif(dif)
    );

    ccs_circ_agen u_agen (
        .bounds_i(q.modb),
        .x_en_i(q.sr[CCS_SR_DMX]),
        .y_en_i(q.sr[CCS_SR_DMY]),
        .x_addr_i(x_addr_i),
        .y_addr_i(y_addr_i),
        .x_next_o(x_next),
        .y_next_o(y_next)
    );

    function automatic logic [2:0] steps_of(input logic [1:0] rf);
        logic [2:0] s;
        case (rf)
            CCS_RF_ONE: s = CCS_STEPS_ONE;
            CCS_RF_TWO: s = CCS_STEPS_TWO;
            CCS_RF_THREE: s = CCS_STEPS_THREE;
            CCS_RF_MANY: s = CCS_STEPS_MANY;
            default: s = CCS_STEPS_ONE;
        endcase
        return s;
    endfunction

    always_comb
    begin
        case (sel_i)
            CCS_SEL_SR: rd_mux = q.sr & ~CCS_SR_RSVD_MASK;
            CCS_SEL_RS: rd_mux = q.rs;
            CCS_SEL_RE: rd_mux = q.re;
            CCS_SEL_MOD: rd_mux = q.modb;
            default: rd_mux = '0;
        endcase
    end

    always_comb
    begin
        d = q;
        d.illegal = 1'b0;
        if (op_valid_i)
        begin
            // illegal flagged for disabled DSP ops
            d.illegal = dif.illegal;
            if (!dif.illegal)
            begin
                case (op_i)
                    CCS_OP_LDC, CCS_OP_LDC_MEM:
                    begin
                        case (sel_i)
                            // load may change count and size code
                            CCS_SEL_SR: d.sr = (q.sr & ~dif.sr_wmask) | (wdata_i & dif.sr_wmask);
                            CCS_SEL_RS: d.rs = wdata_i;
                            CCS_SEL_RE: d.re = wdata_i;
                            CCS_SEL_MOD: d.modb = wdata_i;
                            default: d.rs = q.rs;
                        endcase
                        if (op_i == CCS_OP_LDC_MEM)
                        begin
                            d.ptr = ptr_i + CCS_PTR_STEP;
                        end
                    end
                    CCS_OP_STC, CCS_OP_STC_MEM:
                    begin
                        d.rdata = rd_mux;
                        if (op_i == CCS_OP_STC_MEM)
                        begin
                            d.ptr = ptr_i - CCS_PTR_STEP;
                        end
                    end
                    CCS_OP_REPEAT_SETUP_OP:
                    begin
                        // setup writes count and size code
                        d.sr[CCS_SR_RC_LSB +: CCS_SR_RC_W] = rc_i;
                        d.sr[CCS_SR_RF_LSB +: CCS_SR_RF_W] = rf_i;
                    end
                    CCS_OP_LOAD_LOOP_START_OP:
                    begin
                        // loop start from displacement and PC
                        d.rs = pc_i + (disp_i << CCS_DISP_SHIFT);
                    end
                    CCS_OP_LOAD_LOOP_END_OP:
                    begin
                        // loop end from displacement and PC
                        d.re = pc_i + (disp_i << CCS_DISP_SHIFT);
                    end
                    CCS_OP_X_TRANSFER_OP:
                    begin
                        d.xp = x_next;
                    end
                    CCS_OP_Y_TRANSFER_OP:
                    begin
                        d.yp = y_next;
                    end
                    CCS_OP_SINGLE_TRANSFER_OP:
                    begin
                        d.sp = s_addr_i;
                    end
                    default:
                    begin
                        d.sp = q.sp;
                    end
                endcase
            end
        end
        // Flag updates land after any status load in the same cycle
        // true flag from execute
        if (t_we_i)
        begin
            d.sr[CCS_SR_T] = t_i;
        end
        // saturation flag from MAC and DSP
        if (s_we_i)
        begin
            d.sr[CCS_SR_S] = s_i;
        end
        if (qm_we_i)
        begin
            d.sr[CCS_SR_Q] = q_i;
            d.sr[CCS_SR_M] = m_i;
        end
        d.sr = d.sr & ~CCS_SR_RSVD_MASK;
        // bank select only counts when privileged
        d.abank = d.sr[CCS_SR_MD] & d.sr[CCS_SR_RB];
        d.cbank = d.sr[CCS_SR_MD] & ~d.sr[CCS_SR_RB];
        d.steps = steps_of(d.sr[CCS_SR_RF_LSB +: CCS_SR_RF_W]);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q <= '0;
            q.sr <= CCS_SR_RESET;
            q.abank <= 1'b1;
            q.steps <= CCS_STEPS_ONE;
        end
        else
        begin
            q <= d;
        end
    end

    assign status_word_o = q.sr;
    assign loop_start_ptr_o = q.rs;
    assign loop_end_ptr_o = q.re;
    // both circular bounds in one register
    assign circular_bounds_o = q.modb;
    assign ctrl_rdata_o = q.rdata;
    assign illegal_o = q.illegal;
    assign ptr_upd_o = q.ptr;
    assign x_ptr_o = q.xp;
    assign y_ptr_o = q.yp;
    assign s_ptr_o = q.sp;
    assign priv_mode_o = q.sr[CCS_SR_MD];
    assign active_bank_o = q.abank;
    assign ctrl_bank_o = q.cbank;
    assign int_accept_o = !q.sr[CCS_SR_BL];
    assign irq_mask_o = q.sr[CCS_SR_I_LSB +: CCS_SR_I_W];
    assign dsp_en_o = q.sr[CCS_SR_DSP];
    assign loop_steps_o = q.steps;

    property p_rsvd_zero;
        @(posedge clk_i) disable iff (rst_i)
        (status_word_o & CCS_SR_RSVD_MASK) == '0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved status bits not zero");

    property p_repeat_setup_op;
        @(posedge clk_i) disable iff (rst_i)
        (op_valid_i && op_i == CCS_OP_REPEAT_SETUP_OP && dsp_en_o)
        |=> status_word_o[CCS_SR_RC_LSB +: CCS_SR_RC_W] == $past(rc_i)
            && status_word_o[CCS_SR_RF_LSB +: CCS_SR_RF_W] == $past(rf_i);
    endproperty
    a_repeat_setup_op: assert property (p_repeat_setup_op)
        else $error("repeat setup did not write count and size");

    property p_load_loop_start_op;
        @(posedge clk_i) disable iff (rst_i)
        (op_valid_i && op_i == CCS_OP_LOAD_LOOP_START_OP && dsp_en_o)
        |=> loop_start_ptr_o == $past(pc_i) + ($past(disp_i) << CCS_DISP_SHIFT);
    endproperty
    a_load_loop_start_op: assert property (p_load_loop_start_op)
        else $error("loop start setup value wrong");

    property p_dsp_illegal;
        @(posedge clk_i) disable iff (rst_i)
        (op_valid_i && !dsp_en_o && (op_i == CCS_OP_X_TRANSFER_OP || op_i == CCS_OP_REPEAT_SETUP_OP
            || op_i == CCS_OP_DSP_OTHER || (op_i == CCS_OP_LDC && sel_i != CCS_SEL_SR)))
        |=> illegal_o ##1 !illegal_o || $past(op_valid_i);
    endproperty
    a_dsp_illegal: assert property (p_dsp_illegal)
        else $error("DSP op not flagged illegal");

    property p_both_no_wrap;
        @(posedge clk_i) disable iff (rst_i)
        (op_valid_i && op_i == CCS_OP_X_TRANSFER_OP && dsp_en_o
            && status_word_o[CCS_SR_DMX] && status_word_o[CCS_SR_DMY])
        |=> x_ptr_o == $past(x_addr_i);
    endproperty
    a_both_no_wrap: assert property (p_both_no_wrap)
        else $error("pointer wrapped with both enables set");

    property p_x_wrap;
        @(posedge clk_i) disable iff (rst_i)
        (op_valid_i && op_i == CCS_OP_X_TRANSFER_OP && dsp_en_o && status_word_o[CCS_SR_DMX]
            && !status_word_o[CCS_SR_DMY]
            && x_addr_i[CCS_MOD_W-1:0] == circular_bounds_o[CCS_MOD_HI_LSB +: CCS_MOD_W])
        |=> x_ptr_o[CCS_MOD_W-1:0] == $past(circular_bounds_o[CCS_MOD_W-1:0]);
    endproperty
    a_x_wrap: assert property (p_x_wrap)
        else $error("X pointer not reloaded with start bound");

    property p_single_transfer_op_plain;
        @(posedge clk_i) disable iff (rst_i)
        (op_valid_i && op_i == CCS_OP_SINGLE_TRANSFER_OP && dsp_en_o) |=> s_ptr_o == $past(s_addr_i);
    endproperty
    a_single_transfer_op_plain: assert property (p_single_transfer_op_plain)
        else $error("single transfer pointer modified");

    property p_post_inc;
        @(posedge clk_i) disable iff (rst_i)
        (op_valid_i && op_i == CCS_OP_LDC_MEM && !dif.illegal)
        |=> ptr_upd_o == $past(ptr_i) + CCS_PTR_STEP;
    endproperty
    a_post_inc: assert property (p_post_inc)
        else $error("load pointer not advanced by four");

    property p_user_md_kept;
        @(posedge clk_i) disable iff (rst_i)
        (op_valid_i && op_i == CCS_OP_LDC && sel_i == CCS_SEL_SR
            && !priv_mode_o && dsp_en_o)
        |=> $stable(priv_mode_o) && $stable(int_accept_o) && dsp_en_o;
    endproperty
    a_user_md_kept: assert property (p_user_md_kept)
        else $error("user load changed protected bits");

    property p_int_hold;
        @(posedge clk_i) disable iff (rst_i)
        int_accept_o != status_word_o[CCS_SR_BL];
    endproperty
    a_int_hold: assert property (p_int_hold)
        else $error("interrupt accept disagrees with hold bit");

    property p_bank;
        @(posedge clk_i) disable iff (rst_i)
        active_bank_o == (priv_mode_o && status_word_o[CCS_SR_RB])
            && !(active_bank_o && ctrl_bank_o);
    endproperty
    a_bank: assert property (p_bank)
        else $error("bank select wrong");

    property p_steps;
        @(posedge clk_i) disable iff (rst_i)
        status_word_o[CCS_SR_RF_LSB +: CCS_SR_RF_W] == CCS_RF_MANY
            |-> loop_steps_o == CCS_STEPS_MANY;
    endproperty
    a_steps: assert property (p_steps)
        else $error("size code 10 not decoded as four or more");
endmodule // ccs_ctrl_regs
`default_nettype wire

// *** ccs_dec_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface ccs_dec_if;
    import ccs_pkg::*;
    ccs_op_t op;
    ccs_sel_t sel;
    logic priv;
    logic dsp;
    logic illegal;
    logic [31:0] sr_wmask;
    modport host (output op, output sel, output priv, output dsp,
                  input illegal, input sr_wmask);
    modport dec (input op, input sel, input priv, input dsp,
                 output illegal, output sr_wmask);
endinterface
`default_nettype wire

// *** ccs_decode.sv ***
`timescale 1ns/100ps
`default_nettype none
module ccs_decode
    import ccs_pkg::*;
(
    ccs_dec_if.dec dif
);
    always_comb
    begin
        dif.illegal = 1'b0;
        dif.sr_wmask = CCS_SR_FULL_MASK;
        case (dif.op)
            CCS_OP_LDC, CCS_OP_LDC_MEM, CCS_OP_STC, CCS_OP_STC_MEM:
            begin
                if (dif.sel == CCS_SEL_SR)
                begin
                    // user mode writes only loop and circular bits
                    dif.illegal = !dif.priv && !dif.dsp;
                    dif.sr_wmask = dif.priv ? CCS_SR_FULL_MASK : CCS_SR_USER_MASK;
                end
                else
                begin
                    // loop and bounds access needs DSP on
                    dif.illegal = !dif.dsp;
                end
            end
            CCS_OP_REPEAT_SETUP_OP, CCS_OP_LOAD_LOOP_START_OP, CCS_OP_LOAD_LOOP_END_OP, CCS_OP_X_TRANSFER_OP, CCS_OP_Y_TRANSFER_OP,
            CCS_OP_SINGLE_TRANSFER_OP, CCS_OP_DSP_OTHER:
            begin
                dif.illegal = !dif.dsp;
            end
            default:
            begin
                dif.illegal = 1'b0;
            end
        endcase
    end
endmodule // ccs_decode
`default_nettype wire

// *** ccs_pipe_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module ccs_pipe_model
    import ccs_pkg::*;
(
    input wire logic clk_i,
    output var logic op_valid_o,
    output var ccs_op_t op_o,
    output var ccs_sel_t sel_o,
    output var logic [31:0] wdata_o,
    output var logic [31:0] ptr_o
);
    initial
    begin
        op_valid_o = 1'h0;
        op_o = CCS_OP_NONE;
        sel_o = CCS_SEL_SR;
        wdata_o = 32'h0;
        ptr_o = 32'h0;
    end

    task automatic issue(input ccs_op_t o, input ccs_sel_t s, input logic [31:0] w,
                         input logic [31:0] p);
        @(negedge clk_i);
        op_valid_o = 1'h1;
        op_o = o;
        sel_o = s;
        wdata_o = w;
        ptr_o = p;
        @(negedge clk_i);
        op_valid_o = 1'h0;
        op_o = CCS_OP_NONE;
        // Released lines show junk, not the last word
        wdata_o = ~wdata_o;
        ptr_o = ~ptr_o;
    endtask
endmodule // ccs_pipe_model
`default_nettype wire

// *** ccs_pkg.sv ***
`default_nettype none
package ccs_pkg;
    // Status word field positions
    localparam int CCS_SR_T = 0;
    localparam int CCS_SR_S = 1;
    localparam int CCS_SR_RF_LSB = 2;
    localparam int CCS_SR_RF_W = 2;
    localparam int CCS_SR_I_LSB = 4;
    localparam int CCS_SR_I_W = 4;
    localparam int CCS_SR_Q = 8;
    localparam int CCS_SR_M = 9;
    localparam int CCS_SR_DMX = 10;
    localparam int CCS_SR_DMY = 11;
    localparam int CCS_SR_DSP = 12;
    localparam int CCS_SR_RC_LSB = 16;
    localparam int CCS_SR_RC_W = 12;
    localparam int CCS_SR_BL = 28;
    localparam int CCS_SR_RB = 29;
    localparam int CCS_SR_MD = 30;
    localparam logic [31:0] CCS_SR_RSVD_MASK = 32'h8000_e000;
    localparam logic [31:0] CCS_SR_FULL_MASK = 32'h7fff_1fff;
    // Bits a user-mode signal-processing load may change
    localparam logic [31:0] CCS_SR_USER_MASK = 32'h0fff_0c0c;
    // Privileged, bank 1, interrupts held, mask level 15
    localparam logic [31:0] CCS_SR_RESET = 32'h7000_00f0;
    // Circular bounds layout: high half end, low half start
    localparam int CCS_MOD_HI_LSB = 16;
    localparam int CCS_MOD_W = 16;
    localparam logic [31:0] CCS_PTR_STEP = 32'h0000_0004;
    localparam int CCS_DISP_SHIFT = 1;
    // Loop size codes and decoded body lengths
    localparam logic [1:0] CCS_RF_ONE = 2'h0;
    localparam logic [1:0] CCS_RF_TWO = 2'h1;
    localparam logic [1:0] CCS_RF_THREE = 2'h3;
    localparam logic [1:0] CCS_RF_MANY = 2'h2;
    localparam logic [2:0] CCS_STEPS_ONE = 3'h1;
    localparam logic [2:0] CCS_STEPS_TWO = 3'h2;
    localparam logic [2:0] CCS_STEPS_THREE = 3'h3;
    localparam logic [2:0] CCS_STEPS_MANY = 3'h4;

    typedef enum logic [3:0] {
        CCS_OP_NONE, CCS_OP_LDC, CCS_OP_LDC_MEM, CCS_OP_STC, CCS_OP_STC_MEM,
        CCS_OP_REPEAT_SETUP_OP, CCS_OP_LOAD_LOOP_START_OP, CCS_OP_LOAD_LOOP_END_OP, CCS_OP_X_TRANSFER_OP, CCS_OP_Y_TRANSFER_OP,
        CCS_OP_SINGLE_TRANSFER_OP, CCS_OP_DSP_OTHER
    } ccs_op_t;

    typedef enum logic [1:0] {
        CCS_SEL_SR, CCS_SEL_RS, CCS_SEL_RE, CCS_SEL_MOD
    } ccs_sel_t;

    typedef struct packed {
        logic [31:0] sr;
        logic [31:0] rs;
        logic [31:0] re;
        logic [31:0] modb;
        logic [31:0] rdata;
        logic illegal;
        logic [31:0] ptr;
        logic [31:0] xp;
        logic [31:0] yp;
        logic [31:0] sp;
        logic abank;
        logic cbank;
        logic [2:0] steps;
    } ccs_state_t;
endpackage
`default_nettype wire

// *** tb_ccs_ctrl_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_ccs_ctrl_regs;
    import ccs_pkg::*;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic op_valid_i, t_we_i, t_i, s_we_i, s_i, qm_we_i, q_i, m_i;
    ccs_op_t op_i;
    ccs_sel_t sel_i;
    logic [31:0] wdata_i, ptr_i, disp_i, pc_i, x_addr_i, y_addr_i, s_addr_i;
    logic [11:0] rc_i;
    logic [1:0] rf_i;
    logic [31:0] status_word_o, loop_start_ptr_o, loop_end_ptr_o, circular_bounds_o;
    logic [31:0] ctrl_rdata_o, ptr_upd_o, x_ptr_o, y_ptr_o, s_ptr_o;
    logic illegal_o, priv_mode_o, active_bank_o, ctrl_bank_o, int_accept_o, dsp_en_o;
    logic [3:0] irq_mask_o;
    logic [2:0] loop_steps_o;
    int n_errors = 0;
    int num_checks = 0;

    always #20 clk_i = ~clk_i;

    ccs_pipe_model i_ccs_pipe_model (.clk_i, .op_valid_o(op_valid_i), .op_o(op_i),
        .sel_o(sel_i), .wdata_o(wdata_i), .ptr_o(ptr_i));

    ccs_ctrl_regs i_ccs_ctrl_regs (.clk_i, .rst_i, .op_valid_i, .op_i, .sel_i, .wdata_i,
        .ptr_i, .rc_i, .rf_i, .disp_i, .pc_i, .x_addr_i, .y_addr_i, .s_addr_i, .t_we_i,
        .t_i, .s_we_i, .s_i, .qm_we_i, .q_i, .m_i, .status_word_o, .loop_start_ptr_o,
        .loop_end_ptr_o, .circular_bounds_o, .ctrl_rdata_o, .illegal_o, .ptr_upd_o,
        .x_ptr_o, .y_ptr_o, .s_ptr_o, .priv_mode_o, .active_bank_o, .ctrl_bank_o,
        .int_accept_o, .irq_mask_o, .dsp_en_o, .loop_steps_o);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic run(ccs_op_t o, ccs_sel_t s, logic [31:0] w, logic [31:0] p);
        i_ccs_pipe_model.issue(o, s, w, p);
    endtask

    task automatic mov(ccs_op_t o, logic [31:0] a);
        x_addr_i = a;
        y_addr_i = a;
        s_addr_i = a;
        run(o, CCS_SEL_SR, 32'h0, 32'h0);
    endtask

    task automatic flags(logic v);
        {t_we_i, s_we_i, qm_we_i, t_i, s_i, q_i, m_i} = {3'h7, {4{v}}};
        @(negedge clk_i);
        {t_we_i, s_we_i, qm_we_i} = 3'h0;
    endtask

    task automatic t_reset();
        check(status_word_o, CCS_SR_RESET);
        check(priv_mode_o, 1'h1);
        check(active_bank_o, 1'h1);
        check(ctrl_bank_o, 1'h0);
        check(int_accept_o, 1'h0);
        check(irq_mask_o, 4'hf);
        check(dsp_en_o, 1'h0);
        check(loop_steps_o, 3'h1);
    endtask

    task automatic t_illegal();
        run(CCS_OP_LOAD_LOOP_START_OP, CCS_SEL_SR, 32'h0, 32'h0);
        check(illegal_o, 1'h1);
        check(loop_start_ptr_o, 32'h0);
        mov(CCS_OP_X_TRANSFER_OP, 32'h0000_1234);
        check(illegal_o, 1'h1);
        check(x_ptr_o, 32'h0);
        @(negedge clk_i);
        check(illegal_o, 1'h0);
    endtask

    task automatic t_sr_load();
        run(CCS_OP_LDC, CCS_SEL_SR, 32'hffff_ffff, 32'h0);
        check(status_word_o, 32'h7fff_1fff);
        check(loop_steps_o, 3'h3);
        check(int_accept_o, 1'h0);
        check(dsp_en_o, 1'h1);
        run(CCS_OP_LDC, CCS_SEL_SR, 32'h4000_1000, 32'h0);
        check(active_bank_o, 1'h0);
        check(ctrl_bank_o, 1'h1);
        check(int_accept_o, 1'h1);
        check(irq_mask_o, 4'h0);
        check(illegal_o, 1'h0);
    endtask

    task automatic t_repeat_setup_op();
        logic [2:0] steps [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
        for (int i = 0; i < 4; i++)
        begin
            rc_i = (i == 3) ? 12'hfff : 12'h5a0 + 12'(i);
            rf_i = 2'(i);
            run(CCS_OP_REPEAT_SETUP_OP, CCS_SEL_SR, 32'h0, 32'h0);
            check(status_word_o[27:16], rc_i);
            check(status_word_o[3:2], rf_i);
            check(loop_steps_o, steps[i]);
        end
    endtask

    task automatic t_loop();
        pc_i = 32'h0000_0100;
        disp_i = 32'h0000_0004;
        run(CCS_OP_LOAD_LOOP_START_OP, CCS_SEL_SR, 32'h0, 32'h0);
        check(loop_start_ptr_o, 32'h0000_0108);
        pc_i = 32'h0000_0200;
        disp_i = 32'hffff_fffe;
        run(CCS_OP_LOAD_LOOP_END_OP, CCS_SEL_SR, 32'h0, 32'h0);
        check(loop_end_ptr_o, 32'h0000_01fc);
        run(CCS_OP_LDC, CCS_SEL_RS, 32'h1234_5678, 32'h0);
        check(loop_start_ptr_o, 32'h1234_5678);
        run(CCS_OP_STC_MEM, CCS_SEL_RS, 32'h0, 32'h0000_2000);
        check(ctrl_rdata_o, 32'h1234_5678);
        check(ptr_upd_o, 32'h0000_1ffc);
    endtask

    task automatic t_bounds();
        run(CCS_OP_LDC_MEM, CCS_SEL_MOD, 32'h0120_0100, 32'h0000_1000);
        check(circular_bounds_o, 32'h0120_0100);
        check(ptr_upd_o, 32'h0000_1004);
        run(CCS_OP_LDC_MEM, CCS_SEL_RE, 32'h00ab_cdef, 32'hffff_fffc);
        check(ptr_upd_o, 32'h0);
        run(CCS_OP_STC, CCS_SEL_RE, 32'h0, 32'h0);
        check(ctrl_rdata_o, 32'h00ab_cdef);
        run(CCS_OP_STC, CCS_SEL_MOD, 32'h0, 32'h0);
        check(ctrl_rdata_o, 32'h0120_0100);
    endtask

    task automatic t_circ();
        run(CCS_OP_LDC, CCS_SEL_SR, 32'h4000_1400, 32'h0);
        mov(CCS_OP_X_TRANSFER_OP, 32'h5555_0120);
        check(x_ptr_o, 32'h5555_0100);
        mov(CCS_OP_X_TRANSFER_OP, 32'h5555_0122);
        check(x_ptr_o, 32'h5555_0122);
        mov(CCS_OP_Y_TRANSFER_OP, 32'h0000_0120);
        check(y_ptr_o, 32'h0000_0120);
        mov(CCS_OP_SINGLE_TRANSFER_OP, 32'h0000_0120);
        check(s_ptr_o, 32'h0000_0120);
        run(CCS_OP_LDC, CCS_SEL_SR, 32'h4000_1800, 32'h0);
        mov(CCS_OP_Y_TRANSFER_OP, 32'h0000_0120);
        check(y_ptr_o, 32'h0000_0100);
        mov(CCS_OP_X_TRANSFER_OP, 32'h0000_0120);
        check(x_ptr_o, 32'h0000_0120);
        run(CCS_OP_LDC, CCS_SEL_SR, 32'h4000_1c00, 32'h0);
        mov(CCS_OP_X_TRANSFER_OP, 32'h0000_0120);
        check(x_ptr_o, 32'h0000_0120);
        mov(CCS_OP_Y_TRANSFER_OP, 32'h0000_0120);
        check(y_ptr_o, 32'h0000_0120);
    endtask

    task automatic t_user();
        run(CCS_OP_LDC, CCS_SEL_SR, 32'h0000_1000, 32'h0);
        check(priv_mode_o, 1'h0);
        check(active_bank_o, 1'h0);
        check(ctrl_bank_o, 1'h0);
        run(CCS_OP_LDC, CCS_SEL_SR, 32'hffff_ffff, 32'h0);
        check(status_word_o, 32'h0fff_1c0c);
        check(illegal_o, 1'h0);
        flags(1'h1);
        check(status_word_o, 32'h0fff_1f0f);
        flags(1'h0);
        check(status_word_o, 32'h0fff_1c0c);
    endtask

    task automatic finish_test();
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        // Request lines belong to the pipeline model alone
        {t_we_i, t_i, s_we_i, s_i, qm_we_i, q_i, m_i} = 7'h0;
        {disp_i, pc_i, x_addr_i, y_addr_i, s_addr_i} = '0;
        rc_i = 12'h0;
        rf_i = 2'h0;
        repeat (8) @(negedge clk_i);
        t_reset();
        rst_i = 1'h0;
        @(negedge clk_i);
        t_illegal();
        t_sr_load();
        t_repeat_setup_op();
        t_loop();
        t_bounds();
        t_circ();
        t_user();
        finish_test();
    end

    // Run needs about 70 cycles
    initial
    begin
        repeat (3000) @(posedge clk_i);
        n_errors++;
        finish_test();
    end
endmodule // tb_ccs_ctrl_regs
`default_nettype wire
